// ---- spi_err_pkg.sv ----
// Constants for the serial port fault, error and low-power logic.
// Assumes a 32-bit APB bus; each register sits in the low byte of one word.
package spi_err_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] DATA_IDX = 8'h31;
   localparam logic [7:0] CTRL_IDX = 8'h32;
   localparam logic [7:0] CSR_IDX = 8'h33;
   localparam int ADDR_W = 12;

   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction : reg_addr

   // serial_port_control field positions
   localparam int CTRL_IE_BIT = 7;
   localparam int CTRL_PE_BIT = 6;
   localparam int CTRL_RATE2_BIT = 5;
   localparam int CTRL_MS_BIT = 4;
   localparam int CTRL_POL_BIT = 3;
   localparam int CTRL_PHA_BIT = 2;
   localparam int CTRL_RATE1_BIT = 1;
   localparam int CTRL_RATE0_BIT = 0;
   // Lower nibble is undefined after reset; it is forced to zero here
   localparam logic [7:0] CTRL_RST = 8'h00;

   // serial_port_ctrl_status field positions
   localparam int CSR_DONE_BIT = 7;
   localparam int CSR_WRITE_COLLISION_FLAG_BIT = 6;
   localparam int CSR_OVR_BIT = 5;
   localparam int CSR_MODE_FAULT_FLAG_BIT = 4;
   localparam int CSR_SOD_BIT = 2;
   localparam int CSR_SSM_BIT = 1;
   localparam int CSR_SSI_BIT = 0;
   localparam logic [7:0] CSR_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // Master serial clock half period and byte framing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MASTER_HALF_PS = 20000;
   localparam logic [3:0] MASTER_HALF_CYC = 4'(MASTER_HALF_PS / CLK_PERIOD_PS);
   localparam logic [4:0] EDGES_PER_BYTE = 5'd16;

endpackage : spi_err_pkg

// ---- spi_fault_power.sv ----
// Serial port core with mode fault, overrun, write collision, interrupt and
// wait/halt handling, reached over APB.
// Assumes pclk at 200 MHz; pins arrive from another serial port unsynchronised.
//
// Summary of operation
// RQ1: In master mode a low internal select sets the mode fault flag.
// RQ2: Mode fault clears port enable, releasing every pin.
// RQ3: Mode fault clears master select, falling back to slave.
// RQ4: Mode fault clears by status read while set, then control write.
// RQ5: While faulted, software cannot set port enable or master select outside clearing.
// RQ6: Fault never sets in slave mode; a set flag persists there.
// RQ7: Far side holds select high while the fault is being cleared.
// RQ8: Byte completing while done flag still set raises the overrun flag.
// RQ9: On overrun the buffer keeps the first byte; later bytes discarded.
// RQ10: Reading the status register clears the overrun flag.
// RQ11: Data write during a transfer is ignored and sets write collision.
// RQ12: Write collision never raises an interrupt.
// RQ13: Done, fault and overrun share one request gated by enable and CPU mask.
// RQ14: Interrupt enable is control bit 7.
// RQ15: Wait mode leaves the port running; its events end wait.
// RQ16: Halt freezes registers; operation resumes after wake-up.
// RQ17: Slave done can wake from halt; fault cannot; extra bytes overrun.
// RQ18: Halt wake-up needs select low at halt entry.
// RQ19: After halt wake-up the master should run one extra transfer.
// RQ20: Single master selects one slave at a time.
// RQ21: Port enable is control bit 6, cleared by reset.
// RQ22: Control layout: enable, port enable, rate2, master, polarity, phase, rate1, rate0.
// RQ23: Software select mode takes internal select from the software level bit.
// RQ24: Done flag clears by status access then data read or write.
// RQ25: Write collision clears by status read then data read.
// RQ26: Fault detection uses the internal select level.
`timescale 1ns/1ps
module spi_fault_power
   import spi_err_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in,
   // CPU and power management
   input wire logic cpu_irq_mask,
   input wire logic wait_mode,
   input wire logic halt_mode,
   output logic irq_req,
   output logic wait_exit,
   output logic halt_wake
);

   typedef struct packed {
      logic sck_s1;
      logic sck_s2;
      logic sck_prev;
      logic mosi_s1;
      logic mosi_s2;
      logic miso_s1;
      logic miso_s2;
      logic ss_s1;
      logic ss_s2;
      logic ss_prev;
      logic [7:0] ctrl;
      logic [2:0] csr_cfg;
      logic done;
      logic write_collision_flag;
      logic overrun_flag;
      logic mode_fault_flag;
      logic mode_fault_flag_armed;
      logic done_armed;
      logic write_collision_flag_armed;
      logic [7:0] rxbuf;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [4:0] edges;
      logic mbusy;
      logic [3:0] div;
      logic sck_o;
      logic out_bit;
      logic halt_prev;
      logic halt_ok;
      logic wake;
      logic ready;
      logic slverr;
      logic [7:0] rdata;
      logic irq;
      logic wexit;
      logic sck_en;
      logic mosi_en;
      logic miso_en;
   } state_s;

   state_s q;
   state_s d;

   logic access;
   logic hit_data;
   logic hit_ctrl;
   logic hit_csr;
   logic ss_int_n;
   logic master;
   logic pe;
   logic clock_capture_phase;
   logic sck_edge;
   logic cap_edge;
   logic drv_edge;
   logic busy;
   logic in_bit;
   logic halted;
   logic done_ev;
   logic [4:0] edge_no;
   logic [7:0] wbyte;
   logic [7:0] byte_rx;
   logic [7:0] next_ctrl;

   always_comb begin
      d = q;
      wbyte = pwdata[7:0];
      // Default keeps the control value when no control write is decoded,
      // so the lock logic below never infers a latch
      next_ctrl = q.ctrl;
      access = psel && penable && q.ready;
      hit_data = 1'b0;
      hit_ctrl = 1'b0;
      hit_csr = 1'b0;
      if (paddr == reg_addr(DATA_IDX)) begin
         hit_data = 1'b1;
      end else if (paddr == reg_addr(CTRL_IDX)) begin
         hit_ctrl = 1'b1;
      end else if (paddr == reg_addr(CSR_IDX)) begin
         hit_csr = 1'b1;
      end
      master = q.ctrl[CTRL_MS_BIT];
      pe = q.ctrl[CTRL_PE_BIT];
      clock_capture_phase = q.ctrl[CTRL_PHA_BIT];
      halted = halt_mode;

      // Pin synchronisers
      d.sck_s1 = sck_in;
      d.sck_s2 = q.sck_s1;
      d.sck_prev = q.sck_s2;
      d.mosi_s1 = mosi_in;
      d.mosi_s2 = q.mosi_s1;
      d.miso_s1 = miso_in;
      d.miso_s2 = q.miso_s1;
      d.ss_s1 = ss_n_in;
      d.ss_s2 = q.ss_s1;

      // RQ23 software select
      ss_int_n = q.csr_cfg[CSR_SSM_BIT] ? q.csr_cfg[CSR_SSI_BIT] : q.ss_s2;
      d.ss_prev = ss_int_n;

      // RQ18 select level caught at halt entry
      d.halt_prev = halt_mode;
      if (halt_mode && !q.halt_prev) begin
         d.halt_ok = !ss_int_n && pe && !master;
      end
      if (!halt_mode) begin
         d.halt_ok = 1'b0;
         d.wake = 1'b0;
      end

      // Serial clock edges: generated in master mode, sampled in slave mode
      sck_edge = 1'b0;
      busy = master ? q.mbusy : (q.edges != 5'd0);
      if (master && pe && q.mbusy && !halted) begin
         if (q.div == MASTER_HALF_CYC - 4'd1) begin
            d.div = 4'd0;
            d.sck_o = !q.sck_o;
            sck_edge = 1'b1;
         end else begin
            d.div = q.div + 4'd1;
         end
      end else if (!master && pe && !ss_int_n && (!halted || q.halt_ok)) begin
         sck_edge = q.sck_s2 != q.sck_prev;
      end
      if (!master && ss_int_n) begin
         d.edges = 5'd0;
      end

      edge_no = q.edges + 5'd1;
      cap_edge = sck_edge && (edge_no[0] ^ clock_capture_phase);
      drv_edge = sck_edge && !(edge_no[0] ^ clock_capture_phase);
      in_bit = master ? q.miso_s2 : q.mosi_s2;
      done_ev = 1'b0;
      byte_rx = {q.rx[6:0], in_bit};
      if (sck_edge) begin
         d.edges = edge_no;
         if (cap_edge) begin
            d.rx = byte_rx;
         end
         if (drv_edge && edge_no != EDGES_PER_BYTE) begin
            d.out_bit = q.tx[7];
            d.tx = {q.tx[6:0], 1'b0};
         end
         if (edge_no == EDGES_PER_BYTE) begin
            done_ev = 1'b1;
            d.edges = 5'd0;
            d.mbusy = 1'b0;
            d.div = 4'd0;
            if (!cap_edge) begin
               byte_rx = q.rx;
            end
         end
      end

      // APB: one wait state, then a completing access phase
      d.ready = psel && penable && !q.ready;
      d.slverr = 1'b0;
      if (psel && penable && !q.ready) begin
         d.slverr = !(hit_data || hit_ctrl || hit_csr);
         if (hit_data) begin
            d.rdata = q.rxbuf;
         end else if (hit_ctrl) begin
            d.rdata = q.ctrl;
         end else if (hit_csr) begin
            d.rdata = {q.done, q.write_collision_flag, q.overrun_flag, q.mode_fault_flag, 1'b0, q.csr_cfg};
         end else begin
            d.rdata = 8'h00;
         end
      end

      // Register side effects; RQ16 frozen during halt
      if (access && !halted) begin
         if (hit_csr) begin
            // RQ24 done armed by any status access
            d.done_armed = q.done;
            if (!pwrite) begin
               // RQ4 fault clearing armed by status read
               d.mode_fault_flag_armed = q.mode_fault_flag;
               // RQ25 collision clearing armed
               d.write_collision_flag_armed = q.write_collision_flag;
               // RQ10 overrun cleared by status read
               d.overrun_flag = 1'b0;
            end else begin
               d.csr_cfg = {wbyte[CSR_SOD_BIT], wbyte[CSR_SSM_BIT], wbyte[CSR_SSI_BIT]};
            end
         end else if (hit_ctrl && pwrite) begin
            next_ctrl = wbyte;
            // RQ5 enable and master locked while faulted
            if (q.mode_fault_flag && !q.mode_fault_flag_armed) begin
               next_ctrl[CTRL_PE_BIT] = q.ctrl[CTRL_PE_BIT];
               next_ctrl[CTRL_MS_BIT] = q.ctrl[CTRL_MS_BIT];
            end
            // RQ22 RQ14 RQ21 control layout
            d.ctrl = next_ctrl;
            // RQ4 control write completes clearing
            if (q.mode_fault_flag_armed) begin
               d.mode_fault_flag = 1'b0;
               d.mode_fault_flag_armed = 1'b0;
            end
         end else if (hit_data) begin
            // RQ24 data access clears done
            if (q.done_armed) begin
               d.done = 1'b0;
               d.done_armed = 1'b0;
            end
            if (!pwrite && q.write_collision_flag_armed) begin
               // RQ25 data read clears collision
               d.write_collision_flag = 1'b0;
               d.write_collision_flag_armed = 1'b0;
            end
            if (pwrite) begin
               if (busy) begin
                  // RQ11 write ignored, collision flagged
                  d.write_collision_flag = 1'b1;
               end else if (!q.done || q.done_armed) begin
                  d.tx = wbyte;
                  d.edges = 5'd0;
                  if (!clock_capture_phase) begin
                     d.out_bit = wbyte[7];
                     d.tx = {wbyte[6:0], 1'b0};
                  end
                  if (master && pe) begin
                     d.mbusy = 1'b1;
                     d.div = 4'd0;
                  end
               end
            end
         end
      end

      // RQ8 RQ9 completed byte, set wins over clear
      if (done_ev) begin
         if (q.done) begin
            d.overrun_flag = 1'b1;
            // Set wins over a data access clearing done in the same cycle
            d.done = 1'b1;
         end else begin
            d.rxbuf = byte_rx;
            d.done = 1'b1;
            d.done_armed = 1'b0;
         end
         // RQ17 slave done wakes from halt
         if (halted && q.halt_ok) begin
            d.wake = 1'b1;
         end
      end

      // RQ1 RQ26 RQ6 fault only in master mode
      if (master && !ss_int_n && !halted) begin
         d.mode_fault_flag = 1'b1;
         d.mode_fault_flag_armed = 1'b0;
         // RQ2 port released
         d.ctrl[CTRL_PE_BIT] = 1'b0;
         // RQ3 back to slave
         d.ctrl[CTRL_MS_BIT] = 1'b0;
         d.mbusy = 1'b0;
         d.edges = 5'd0;
      end
      if (!d.ctrl[CTRL_MS_BIT] || !d.ctrl[CTRL_PE_BIT]) begin
         d.mbusy = 1'b0;
      end
      if (!d.mbusy) begin
         d.sck_o = d.ctrl[CTRL_POL_BIT];
      end

      // RQ13 RQ12 one request; collision excluded
      d.irq = q.ctrl[CTRL_IE_BIT] && (q.done || q.mode_fault_flag || q.overrun_flag) && !cpu_irq_mask;
      // RQ15 events end wait
      d.wexit = wait_mode && q.ctrl[CTRL_IE_BIT] && (q.done || q.mode_fault_flag || q.overrun_flag);

      // RQ2 pin drivers follow port enable
      d.sck_en = d.ctrl[CTRL_PE_BIT] && d.ctrl[CTRL_MS_BIT];
      d.mosi_en = d.sck_en && !d.csr_cfg[2];
      d.miso_en = d.ctrl[CTRL_PE_BIT] && !d.ctrl[CTRL_MS_BIT] && !ss_int_n && !d.csr_cfg[2];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.csr_cfg <= CSR_RST[2:0];
         q.rxbuf <= DATA_RST;
         q.sck_s1 <= 1'b0;
         q.ss_s1 <= 1'b1;
         q.ss_s2 <= 1'b1;
         q.ss_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign prdata = {24'h000000, q.rdata};
   assign pready = q.ready;
   assign pslverr = q.slverr;
   assign sck_out = q.sck_o;
   assign sck_oe = q.sck_en;
   assign mosi_out = q.out_bit;
   assign mosi_oe = q.mosi_en;
   assign miso_out = q.out_bit;
   assign miso_oe = q.miso_en;
   assign irq_req = q.irq;
   assign wait_exit = q.wexit;
   assign halt_wake = q.wake;

endmodule : spi_fault_power

// ---- spi_fault_power_props.sv ----
// Checker for the serial port bus handshake and pin outputs.
// Bound to spi_fault_power; sees its ports only.
`timescale 1ns/1ps
module spi_fault_power_props
   import spi_err_pkg::*;
(
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and power
   input wire logic sck_oe,
   input wire logic miso_oe,
   input wire logic ss_n_in,
   input wire logic cpu_irq_mask,
   input wire logic wait_mode,
   input wire logic halt_mode,
   input wire logic irq_req,
   input wire logic wait_exit,
   input wire logic halt_wake
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_fault_drop: assert property ((sck_oe && !ss_n_in && !halt_mode) [*3] |=> !sck_oe)
      else $error("select low in master left outputs on");
   a_oe_mode: assert property (!(sck_oe && miso_oe))
      else $error("master and slave outputs both on");
   a_irq_mask: assert property (irq_req |-> !$past(cpu_irq_mask))
      else $error("request while masked");
   a_wait_gate: assert property (wait_exit |-> $past(wait_mode) && (irq_req || $past(cpu_irq_mask)))
      else $error("wait exit out of wait or without request");
   a_halt_gate: assert property (halt_wake |-> $past(halt_mode))
      else $error("halt wake outside halt");
endmodule : spi_fault_power_props

bind spi_fault_power spi_fault_power_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sck_oe(sck_oe), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
   .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
   .irq_req(irq_req), .wait_exit(wait_exit), .halt_wake(halt_wake)
);

// ---- spi_peer.sv ----
// Far-side serial master, mode 0, 64 ns link clock inside frames only.
// Driven by bench calls to send and set_sel.
`timescale 1ns/1ps
module spi_peer (
   // Link lines
   output logic sck,
   output logic mosi,
   output logic miso,
   output logic ss_n
);
   logic keep_sel;
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      miso = 1'b0;
      ss_n = 1'b1;
      keep_sel = 1'b0;
   end
   // Slave-out line never shows a stable stale level
   always #7 miso = ~miso;
   task automatic set_sel(input logic v);
      // Move off the bus clock edges
      #1.25;
      keep_sel = !v;
      ss_n = v;
   endtask : set_sel
   task automatic send(input logic [7:0] b);
      // Fractional offset keeps link edges clear of bus clock edges
      #1.25;
      ss_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         #32 sck = 1'b1;
         #32 sck = 1'b0;
      end
      #32 ss_n = !keep_sel;
      mosi = ~mosi;
   endtask : send
endmodule : spi_peer

// ---- tb.sv ----
// Bench for spi_fault_power: APB master, far-side peer, queued read checks.
// Assumes the peer drives the serial input pins.
`timescale 1ns/1ps
module tb;
   import spi_err_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, cpu_irq_mask, wait_mode, halt_mode;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic pready, pslverr, irq_req, wait_exit, halt_wake, sck_oe, miso_oe, mosi_oe, sck, mosi, miso, ss_n;
   logic [9:0] e;
   logic [9:0] expq[$];
   logic [7:0] a;
   int n_mismatch = 0;
   int n_tests = 0;
   spi_fault_power DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck_in(sck), .sck_out(), .sck_oe(sck_oe), .mosi_in(mosi), .mosi_out(), .mosi_oe(mosi_oe),
      .miso_in(miso), .miso_out(), .miso_oe(miso_oe), .ss_n_in(ss_n), .cpu_irq_mask(cpu_irq_mask),
      .wait_mode(wait_mode), .halt_mode(halt_mode), .irq_req(irq_req), .wait_exit(wait_exit),
      .halt_wake(halt_wake)
   );
   spi_peer u_peer (.sck(sck), .mosi(mosi), .miso(miso), .ss_n(ss_n));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction : xs
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t register read %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t output flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Note: {check data, slave error, data}
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic u,
                      input logic [7:0] x);
      int n;
      expq.push_back({u, !(idx inside {DATA_IDX, CTRL_IDX, CSR_IDX}), x});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk_bit(1'b0, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle();
      int n;
      n = 0;
      while ((halt_mode ? halt_wake : irq_req) !== 1'b1 && n < 60) begin
         @(posedge pclk);
         n++;
      end
   endtask : settle
   always @(posedge pclk) if (pready === 1'b1) begin
      e = expq.pop_front();
      chk_bit(pslverr, e[8]);
      if (e[9]) chk_byte(prdata[7:0], e[7:0]);
   end
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      #300000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {presetn, psel, penable, pwrite, cpu_irq_mask, wait_mode, halt_mode} = 7'h00;
      paddr = '0;
      pwdata = '0;
      seed = 32'ha4bf06f3;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_IDX, 8'h00, 1'b1, 8'h00);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h00);
      apb(1'b0, 8'h30, 8'h00, 1'b0, 8'h00);
      wait_mode <= 1'b1;
      apb(1'b1, CTRL_IDX, 8'hc0, 1'b0, 8'h00);
      seed = xs(seed);
      a = seed[7:0];
      u_peer.send(a);
      settle();
      chk_bit(irq_req, 1'b1);
      chk_bit(wait_exit, 1'b1);
      cpu_irq_mask <= 1'b1;
      wait_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_bit(irq_req, 1'b0);
      cpu_irq_mask <= 1'b0;
      seed = xs(seed);
      u_peer.send(seed[7:0]);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'ha0);
      apb(1'b0, DATA_IDX, 8'h00, 1'b1, a);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h00);
      seed = xs(seed);
      a = seed[7:0];
      fork
         u_peer.send(a);
         begin
            repeat (40) @(posedge pclk);
            apb(1'b1, DATA_IDX, ~a, 1'b0, 8'h00);
         end
      join
      settle();
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'hc0);
      apb(1'b0, DATA_IDX, 8'h00, 1'b1, a);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h00);
      u_peer.set_sel(1'b0);
      repeat (6) @(posedge pclk);
      chk_bit(miso_oe, 1'b1);
      halt_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      a = ~a;
      u_peer.send(a);
      settle();
      chk_bit(halt_wake, 1'b1);
      halt_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_bit(halt_wake, 1'b0);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h80);
      apb(1'b0, DATA_IDX, 8'h00, 1'b1, a);
      u_peer.set_sel(1'b1);
      repeat (4) @(posedge pclk);
      u_peer.send(8'h5a);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h80);
      apb(1'b0, DATA_IDX, 8'h00, 1'b1, 8'h5a);
      apb(1'b1, CTRL_IDX, 8'hd0, 1'b0, 8'h00);
      repeat (3) @(posedge pclk);
      chk_bit(sck_oe, 1'b1);
      chk_bit(mosi_oe, 1'b1);
      u_peer.set_sel(1'b0);
      settle();
      chk_bit(sck_oe, 1'b0);
      chk_bit(mosi_oe, 1'b0);
      chk_bit(irq_req, 1'b1);
      u_peer.set_sel(1'b1);
      apb(1'b1, CTRL_IDX, 8'hd0, 1'b0, 8'h00);
      apb(1'b0, CTRL_IDX, 8'h00, 1'b1, 8'h80);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h10);
      apb(1'b1, CTRL_IDX, 8'hd0, 1'b0, 8'h00);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h00);
      apb(1'b0, CTRL_IDX, 8'h00, 1'b1, 8'hd0);
      apb(1'b1, CSR_IDX, 8'h02, 1'b0, 8'h00);
      apb(1'b0, CSR_IDX, 8'h00, 1'b1, 8'h12);
      apb(1'b0, CTRL_IDX, 8'h00, 1'b1, 8'h80);
      print_verdict();
   end
endmodule : tb
